//--- blink_divider.sv
// free-running divider: toggles a phase output every half_cycles clocks
module blink_divider #(
    parameter int unsigned HALF_CYCLES = 1000
) (
    input  wire logic clock,   // system clock
    input  wire logic rst,     // synchronous reset
    output logic      phase    // square wave, registered
);
    // elaboration-time refusal of a divider too short to count
    if (HALF_CYCLES < 2) begin : g_bad_half
        $error("blink_divider needs at least two cycles");
    end

    localparam int W = $clog2(HALF_CYCLES);
    logic [W-1:0] count_r;
    logic         wrap;

    assign wrap = (count_r == W'(HALF_CYCLES - 1));

    // count then flip the phase
    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= '0;
            phase   <= 1'b0;
        end else if (wrap) begin
            count_r <= '0;
            phase   <= ~phase;
        end else begin
            count_r <= count_r + W'(1);
        end
    end
endmodule // blink_divider

//--- lamp_watch.sv
module lamp_watch
    import led_status_pkg::*;
(
    input  wire logic       clock, // system clock
    input  wire led_drive_t lamp,  // one port's lamp drive
    output int              span   // cycles between last two changes
);
    timeunit 1ns;
    timeprecision 1ns;
    led_drive_t last_r;
    int         cnt_r;
    // lamps only show a change, so the gap between changes is the blink rate
    always_ff @(posedge clock) begin
        last_r <= lamp;
        cnt_r  <= (lamp != last_r) ? 1 : cnt_r + 1;
        if (lamp != last_r) span <= cnt_r;
    end
endmodule // lamp_watch

//--- led_enc_monitor.sv
module led_enc_monitor
    import led_status_pkg::*;
#(
    parameter int unsigned NPORTS     = 8,
    parameter int unsigned READY_WAIT = 50
) (
    input wire logic                     clock,          // clock
    input wire logic                     rst,            // reset
    input wire port_state_t [NPORTS-1:0] port_state,     // flags
    input wire logic                     module_present, // module fitted
    input wire logic                     post_done,      // tests over
    input wire logic                     board_pass,     // board good
    input wire logic [NPORTS-1:0]        post_fail,      // port failed
    input wire led_drive_t [NPORTS-1:0]  led,            // lamps
    input wire logic                     ready_led       // ready lamp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    int unsigned since_r;
    // saturating age since reset, so ready can be held to its minimum wait
    always_ff @(posedge clock) since_r <= rst ? 0 : (since_r < 1000 ? since_r + 1 : since_r);
    dark_idle_a: assert property (port_state[0] == 8'h00 && !post_fail[0] |=> led[0] == 2'h0) else $error("lit without carrier");
    carrier_yel_a: assert property (port_state[0] == 8'h80 && !post_fail[0] |=> led[0] == 2'h1) else $error("carrier not yellow");
    online_grn_a: assert property (port_state[0] == 8'hC0 && !post_fail[0] |=> led[0] == 2'h2) else $error("online not green");
    bypass_both_a: assert property (port_state[0] == 8'hC1 && !post_fail[0] |=> led[0] == 2'h3) else $error("bypass not both");
    fail_yel_a: assert property (post_fail[0] |=> led[0] == 2'h1) else $error("failed port not yellow");
    fault_no_grn_a: assert property (port_state[0].fault && !post_fail[0] |=> !led[0].green) else $error("fault shows green");
    module_gone_a: assert property ((!module_present)[*6] |=> led[7] == 2'h0) else $error("empty slot lit");
    ready_gate_a: assert property ((!post_done)[*8] |=> !ready_led) else $error("ready before tests");
    ready_wait_a: assert property (ready_led |-> since_r >= READY_WAIT) else $error("ready too early");
    steady_post_a: assert property ((post_done && port_state[0] == 8'hA0 && !post_fail[0])[*8] |=> led[0] == 2'h1) else $error("blink after tests");
    cover property (port_state[0] == 8'hC2 ##1 led[0] == 2'h2);
    cover property ($rose(ready_led));
    cover property (module_present ##1 led[7] == 2'h2);
endmodule // led_enc_monitor

bind port_led_status_encoder led_enc_monitor #(.NPORTS(NPORTS), .READY_WAIT(READY_WAIT)) mon (.*);

//--- led_status_cfg.svh
`ifndef LED_STATUS_CFG_SVH
`define LED_STATUS_CFG_SVH

`define CLOCK_HZ          25000000
`define SLOW_BLINK_MS     2000
`define FAST_BLINK_MS     500
`define READY_DELAY_MS    120000
`define SLOW_BLINK_CYCLES ((`CLOCK_HZ / 1000) * `SLOW_BLINK_MS)
`define FAST_BLINK_CYCLES ((`CLOCK_HZ / 1000) * `FAST_BLINK_MS)
// 25 MHz times 120 s; written out because the product overflows signed 32-bit math
`define READY_CYCLES      32'hB2D0_5E00
`define FLICKER_CYCLES    32'h0008_0000
`define NUM_PORTS         8
`define MODULE_PORT       7

`endif

//--- led_status_pkg.sv
`include "led_status_cfg.svh"

package led_status_pkg;

    // port condition flags from the port logic
    typedef struct packed {
        logic carrier;
        logic online;
        logic disabled;
        logic fault;
        logic segmented;
        logic loopback;
        logic traffic;
        logic bypassed;
    } port_state_t;

    // two-colour drive for one port
    typedef struct packed {
        logic green;
        logic yellow;
    } led_drive_t;

    typedef enum logic [3:0] {
        PAT_DARK      = 4'h0,
        PAT_YEL_STEADY = 4'h1,
        PAT_YEL_SLOW  = 4'h2,
        PAT_YEL_FAST  = 4'h3,
        PAT_GRN_STEADY = 4'h4,
        PAT_GRN_SLOW  = 4'h5,
        PAT_GRN_FAST  = 4'h6,
        PAT_GRN_FLICK = 4'h7,
        PAT_BOTH      = 4'h8
    } pattern_t;

    typedef enum logic [1:0] {
        POST_RUNNING = 2'h0,
        POST_PASSED  = 2'h1,
        POST_FAILED  = 2'h2
    } post_state_t;

endpackage

//--- port_led_status_encoder.sv
// Summary of operation
// [RULE1] no carrier keeps the port dark
// [RULE2] carrier but not online: steady yellow
// [RULE3] disabled port: slow yellow blink
// [RULE4] fault on port: fast yellow blink
// [RULE5] online without traffic: steady green
// [RULE6] segmented slow green, loopback fast green
// [RULE7] online with frames: green flicker
// [RULE8] bypassed port lights both colours
// [RULE9] slow blink interval two seconds
// [RULE10] fast blink interval half second
// [RULE11] module port dark without transceiver
// [RULE12] port failing self-test shows yellow
// [RULE13] blinking becomes steady after self-test
// [RULE14] ready lamp after passing self-test, delay
// [RULE15] fixed priority among simultaneous conditions
`include "led_status_cfg.svh"

module port_led_status_encoder
    import led_status_pkg::*;
#(
    parameter int unsigned NPORTS      = `NUM_PORTS,
    parameter int unsigned SLOW_CYCLES = `SLOW_BLINK_CYCLES,
    parameter int unsigned FAST_CYCLES = `FAST_BLINK_CYCLES,
    parameter int unsigned FLICK_CYCLES = `FLICKER_CYCLES,
    parameter int unsigned READY_WAIT  = `READY_CYCLES
) (
    input  wire logic                     clock,          // 25 MHz system clock
    input  wire logic                     rst,            // synchronous, active high
    input  wire port_state_t [NPORTS-1:0] port_state,     // per-port condition flags
    input  wire logic                     module_present, // transceiver fitted in port 7
    input  wire logic                     post_done,      // self-test sequence finished
    input  wire logic                     board_pass,     // board tests all passed
    input  wire logic [NPORTS-1:0]        post_fail,      // per-port self-test failure
    output led_drive_t [NPORTS-1:0]       led,            // registered lamp drive
    output logic                          ready_led       // registered ready lamp
);
    // elaboration-time refusal of parameters the logic cannot serve
    if (NPORTS <= `MODULE_PORT) begin : g_bad_ports
        $error("port count must include the module port");
    end
    if (FAST_CYCLES >= SLOW_CYCLES) begin : g_bad_blink
        $error("fast blink must be faster than slow");
    end

    logic slow_ph;
    logic fast_ph;
    logic flick_ph;

    // slow blink toggles once each interval
    blink_divider #(.HALF_CYCLES(SLOW_CYCLES)) u_slow (   // [RULE9]
        .clock (clock),
        .rst   (rst),
        .phase (slow_ph)
    );

    // fast blink toggles once each interval
    blink_divider #(.HALF_CYCLES(FAST_CYCLES)) u_fast (   // [RULE10]
        .clock (clock),
        .rst   (rst),
        .phase (fast_ph)
    );

    // flicker is much faster than blinking, so traffic reads as activity
    blink_divider #(.HALF_CYCLES(FLICK_CYCLES)) u_flick (
        .clock (clock),
        .rst   (rst),
        .phase (flick_ph)
    );

    // pins from outside: three stages, change taken when last two agree
    logic [2:0] pres_s_r;
    logic       pres_r;
    logic [2:0] done_s_r;
    logic       done_r;
    logic [2:0] pass_s_r;
    logic       pass_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            pres_s_r <= 3'h0;
            done_s_r <= 3'h0;
            pass_s_r <= 3'h0;
        end else begin
            pres_s_r <= {pres_s_r[1:0], module_present};
            done_s_r <= {done_s_r[1:0], post_done};
            pass_s_r <= {pass_s_r[1:0], board_pass};
        end
    end

    // filtered levels update only when stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            pres_r <= 1'b0;
            done_r <= 1'b0;
            pass_r <= 1'b0;
        end else begin
            if (pres_s_r[1] == pres_s_r[2]) pres_r <= pres_s_r[2];
            if (done_s_r[1] == done_s_r[2]) done_r <= done_s_r[2];
            if (pass_s_r[1] == pass_s_r[2]) pass_r <= pass_s_r[2];
        end
    end

    // ready delay counter from start-up; saturates at the wait
    localparam int RW = $clog2(READY_WAIT + 1);
    logic [RW-1:0] up_cnt_r;
    logic          waited;
    logic          ready_nxt;

    assign waited    = (up_cnt_r == RW'(READY_WAIT));
    assign ready_nxt = waited & done_r & pass_r;              // [RULE14]

    always_ff @(posedge clock) begin
        if (rst) up_cnt_r <= '0;
        else if (!waited) up_cnt_r <= up_cnt_r + RW'(1);
    end

    always_ff @(posedge clock) begin
        if (rst) ready_led <= 1'b0;
        else ready_led <= ready_nxt;
    end

    // per-port pattern selection and lamp drive
    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_port
            port_state_t s;
            pattern_t    pat;
            logic        absent;
            logic        steady;
            logic        blink_slow;
            logic        blink_fast;
            led_drive_t  drv;

            assign s      = port_state[p];
            // only the module port can lack its transceiver
            assign absent = (p == `MODULE_PORT) && !pres_r;          // [RULE11]
            // while self-test runs, blinks are shown; afterwards they freeze lit
            assign steady     = done_r;                              // [RULE13]
            assign blink_slow = steady | slow_ph;
            assign blink_fast = steady | fast_ph;

            // fixed priority, highest first
            assign pat =
                absent                   ? PAT_DARK       :          // [RULE11]
                post_fail[p]             ? PAT_YEL_STEADY :          // [RULE12]
                s.fault                  ? PAT_YEL_FAST   :          // [RULE4] [RULE15]
                s.disabled               ? PAT_YEL_SLOW   :          // [RULE3]
                s.bypassed               ? PAT_BOTH       :          // [RULE8]
                s.loopback               ? PAT_GRN_FAST   :          // [RULE6]
                (s.online && s.segmented) ? PAT_GRN_SLOW  :          // [RULE6]
                (s.online && s.traffic)  ? PAT_GRN_FLICK  :          // [RULE7]
                s.online                 ? PAT_GRN_STEADY :          // [RULE5]
                s.carrier                ? PAT_YEL_STEADY :          // [RULE2]
                                           PAT_DARK;                 // [RULE1]

            // pattern to colours
            always_comb begin
                drv = '{green: 1'b0, yellow: 1'b0};
                case (pat)
                    PAT_DARK:       drv = '{green: 1'b0, yellow: 1'b0};
                    PAT_YEL_STEADY: drv.yellow = 1'b1;
                    PAT_YEL_SLOW:   drv.yellow = blink_slow;
                    PAT_YEL_FAST:   drv.yellow = blink_fast;
                    PAT_GRN_STEADY: drv.green = 1'b1;
                    PAT_GRN_SLOW:   drv.green = blink_slow;
                    PAT_GRN_FAST:   drv.green = blink_fast;
                    PAT_GRN_FLICK:  drv.green = flick_ph;            // [RULE7]
                    PAT_BOTH:       drv = '{green: 1'b1, yellow: 1'b1};
                    default:        drv = '{green: 1'b0, yellow: 1'b0};
                endcase
            end

            // registered lamp outputs
            always_ff @(posedge clock) begin
                if (rst) led[p] <= '{green: 1'b0, yellow: 1'b0};
                else led[p] <= drv;
            end
        end
    endgenerate
endmodule // port_led_status_encoder

//--- tb_top.sv
module tb_top
    import led_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clock = 0, rst = 1, module_present = 0, post_done = 0, board_pass = 0;
    port_state_t [7:0] port_state = {8'hC0, 56'h0};
    logic [7:0]        post_fail = 8'h00;
    led_drive_t [7:0]  led;
    logic              ready_led;
    int                span, err_total = 0, num_checks = 0;

    always #20 clock = ~clock;

    port_led_status_encoder #(.SLOW_CYCLES(20), .FAST_CYCLES(6), .FLICK_CYCLES(2),
        .READY_WAIT(50)) dut (.*);
    lamp_watch pm (.clock(clock), .lamp(led[0]), .span(span));

    task automatic chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // drive one state on port 0, then compare lit colour and toggle gap
    task automatic try(input logic [7:0] st, input logic [1:0] exp, input int per);
        int n;
        @(negedge clock) port_state[0] = st;
        repeat (3 * per + 4) @(negedge clock);
        for (n = 0; n < 60 && exp != 2'h0 && led[0] === 2'h0; n++) @(negedge clock);
        chk(led[0] === exp, "wrong colour");
        if (per != 0) chk(span == per, "wrong blink gap");
        $display("state %h done", st);
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        int n;
        repeat (2) @(negedge clock);
        rst = 0;
        try(8'h00, 2'h0, 0);
        try(8'h80, 2'h1, 0);
        try(8'hA0, 2'h1, 20);
        try(8'h90, 2'h1, 6);
        try(8'hC0, 2'h2, 0);
        try(8'hC8, 2'h2, 20);
        try(8'hC4, 2'h2, 6);
        try(8'hC2, 2'h2, 2);
        try(8'hC1, 2'h3, 0);
        try(8'hF0, 2'h1, 6);
        chk(led[7] === 2'h0, "empty slot lit");
        module_present = 1;
        repeat (8) @(negedge clock);
        chk(led[7] === 2'h2, "slot 7 not green");
        post_fail[0] = 1;
        repeat (3) @(negedge clock);
        chk(led[0] === 2'h1, "failed port not yellow");
        post_fail[0] = 0;
        port_state[0] = 8'hA0;
        post_done = 1;
        repeat (8) @(negedge clock);
        for (n = 0; n < 30 && led[0] === 2'h1; n++) @(negedge clock);
        chk(n == 30, "not steady after tests");
        chk(ready_led === 1'b0, "ready without board pass");
        board_pass = 1;
        repeat (8) @(negedge clock);
        chk(ready_led === 1'b1, "ready lamp off");
        $display("pins done");
        report_and_stop;
    end

    // a hang must still reach the verdict
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        $display("[FAIL] %0t watchdog", $time);
        report_and_stop;
    end
endmodule // tb_top
